// >>> sscs_params.svh
// constants of the sensor spi configuration slave: framing and timing
// assumes: included by bare name; values in cycles derive in the module
`ifndef SSCS_PARAMS_SVH
`define SSCS_PARAMS_SVH

// framing: 16-bit address then 16-bit data, msb first
`define SSCS_ADDR_BITS 16
`define SSCS_DATA_BITS 16
`define SSCS_FRAME_BITS 6'd32
`define SSCS_ADDR_LAST 6'd15
`define SSCS_DATA_FIRST 6'd16
`define SSCS_FRAME_LAST 6'd31
`define SSCS_WR_FLAG_POS 0
`define SSCS_DATA_RESET 16'h0000

// timing: core clock and worst-case fetch times
`define SSCS_CLK_MHZ 250
`define SSCS_CFG_FETCH_NS 1500
`define SSCS_RUN_FETCH_NS 4500
`define SSCS_SYNC_CYC 4

`endif

// >>> sscs_pkg.sv
// types of the sensor spi configuration slave
// assumes: compiled before sscs_top; no imports are made from it
`default_nettype none

package sscs_pkg;

  // sensor operating state, driven by the sensor sequencer
  typedef enum logic [1:0] {
    SSCS_STANDBY, SSCS_CONFIG, SSCS_IDLE, SSCS_RUNNING
  } sscs_sstate_t;

  // class of a register: states in which it may be set
  typedef enum logic [1:0] {SSCS_ANY, SSCS_IDLE_CFG, SSCS_CFG_ONLY} sscs_class_t;

  // read fetch sequencer
  typedef enum logic {SSCS_WAIT, SSCS_FETCH} sscs_fsm_t;

  // link side, cleared whenever chip select is released
  typedef struct packed {
    logic [5:0] cnt;
    logic [31:0] sh;
    logic rd;
    logic [15:0] out;
  } sscs_frame_t;

  // link side words and toggles handed to the core clock
  typedef struct packed {
    logic wr_tog;
    logic rd_tog;
    logic [15:0] rd_addr;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
  } sscs_xfer_t;

  // core clock side
  typedef struct packed {
    logic wr_s1;
    logic wr_s2;
    logic wr_seen;
    logic rd_s1;
    logic rd_s2;
    logic rd_seen;
    sscs_fsm_t fsm;
    logic [10:0] cnt;
    logic [15:0] rd_addr;
    logic [15:0] rd_data;
    sscs_sstate_t prev;
    logic [15:0] act_data;
  } sscs_core_t;

endpackage : sscs_pkg

`default_nettype wire

// >>> sscs_top.sv
// sensor spi configuration slave: serial link, shadow and active memory
// assumes: I_SCK is the master's clock (cpol 1, cpha 1); I_SENSOR_STATE
// and I_FRAME_START come from logic on I_CLK
// Function
// - the sensor is a slave only; the master makes every transfer and clock.
// - chip select is active low; the link answers only while it is low.
// - read data leaves the sensor serially on its data output.
// - clock idles high, data sampled on rising edge, launched on falling.
// - read data may lag the address by up to 1.5 us in configuration.
// - in running state the read fetch may take up to 4.5 us.
// - every write lands in shadow memory, not in the active settings.
// - shadow moves to active at frame start in an allowed state or on entry to allowed state.
// - reads return shadow contents, the next value, not the active one.
// - configuration-only writes while running apply after a config pass.
// - registers writable in any state accept writes in every state.
`default_nettype none
`include "sscs_params.svh"

module sscs_top #(
  parameter int IDX_W = 6,
  parameter int DEPTH = 1 << IDX_W,
  parameter logic [DEPTH-1:0] CFG_ONLY_MASK = '0,
  parameter logic [DEPTH-1:0] IDLE_CFG_MASK = '0,
  parameter int CFG_FETCH_CYC =
    (`SSCS_CFG_FETCH_NS * `SSCS_CLK_MHZ) / 1000 - `SSCS_SYNC_CYC,
  parameter int RUN_FETCH_CYC =
    (`SSCS_RUN_FETCH_NS * `SSCS_CLK_MHZ) / 1000 - `SSCS_SYNC_CYC
) (
  input wire logic I_CLK, // core clock, 250 MHz
  input wire logic I_RESET_N, // reset, active low; synchronous on the core side, asynchronous for the link words
  input wire logic I_SCK, // serial clock from the master
  input wire logic I_CSN_N, // chip select, active low
  input wire logic I_MOSI, // serial data from the master
  output logic O_MISO, // serial data to the master
  output logic O_MISO_OE, // high while the sensor drives the data line
  input wire sscs_pkg::sscs_sstate_t I_SENSOR_STATE, // sensor state
  input wire logic I_FRAME_START, // one-cycle pulse at frame start
  input wire logic [IDX_W-1:0] I_ACT_IDX, // active setting to look up
  output logic [15:0] O_ACT_DATA // active setting, one cycle later
);

  localparam int CFG_BOUND = 380;
  localparam int RUN_BOUND = 1130;

  sscs_pkg::sscs_frame_t f_r, f_nxt;
  sscs_pkg::sscs_xfer_t x_r, x_nxt;
  sscs_pkg::sscs_core_t c_r, c_nxt;
  logic [15:0] shadow_mem [DEPTH];
  logic [15:0] active_mem [DEPTH];
  logic [31:0] full;
  logic wr_evt;
  logic rd_evt;
  logic state_chg;
  logic miso_r;
  logic [10:0] fetch_age_r;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------

  // register index taken from a word address (lsb is the write flag)
  function automatic logic [IDX_W-1:0] idx_of(input logic [15:0] addr);
    idx_of = addr[IDX_W:1];
  endfunction : idx_of

  // class of a register from the parameter masks
  function automatic sscs_pkg::sscs_class_t class_of(input int i);
    if (CFG_ONLY_MASK[i]) begin
      class_of = sscs_pkg::SSCS_CFG_ONLY;
    end else if (IDLE_CFG_MASK[i]) begin
      class_of = sscs_pkg::SSCS_IDLE_CFG;
    end else begin
      class_of = sscs_pkg::SSCS_ANY;
    end
  endfunction : class_of

  // whether a register class may take effect in a given state
  function automatic logic apply_ok(input sscs_pkg::sscs_class_t cls,
                                    input sscs_pkg::sscs_sstate_t st);
    case (cls)
      sscs_pkg::SSCS_CFG_ONLY: apply_ok = (st == sscs_pkg::SSCS_CONFIG);
      sscs_pkg::SSCS_IDLE_CFG: apply_ok = (st == sscs_pkg::SSCS_CONFIG) ||
                                          (st == sscs_pkg::SSCS_IDLE);
      default: apply_ok = 1'b1;
    endcase
  endfunction : apply_ok

  // --------------------------------------------------------------------
  // link side, clocked by the master's serial clock
  // --------------------------------------------------------------------

  // next state of shift, bit count and returned word
  always_comb begin
    f_nxt = f_r;
    x_nxt = x_r;
    full = {f_r.sh[30:0], I_MOSI}; // msb first
    // rising edge samples the input
    if (f_r.cnt != `SSCS_FRAME_BITS) begin
      f_nxt.sh = full;
      f_nxt.cnt = f_r.cnt + 6'h01;
    end
    // address complete: a clear lsb asks the core for a fetch
    if (f_r.cnt == `SSCS_ADDR_LAST) begin
      f_nxt.rd = !I_MOSI;
      if (!I_MOSI) begin
        x_nxt.rd_tog = !x_r.rd_tog;
        x_nxt.rd_addr = full[15:0];
      end
    end
    // data complete: a set lsb hands the write to the core
    if (f_r.cnt == `SSCS_FRAME_LAST && f_r.sh[15 + `SSCS_WR_FLAG_POS]) begin
      x_nxt.wr_tog = !x_r.wr_tog;
      x_nxt.wr_addr = full[31:16];
      x_nxt.wr_data = full[15:0];
    end
    // the master has waited the fetch time, so the core's read word is
    // stable here; its msb leaves at once, the rest shifts up per edge
    if (f_r.cnt == `SSCS_DATA_FIRST && f_r.rd) begin
      f_nxt.out = {c_r.rd_data[14:0], 1'b0};
    end else begin
      f_nxt.out = {f_r.out[14:0], 1'b0};
    end
  end

  // shift and count registers, cleared by chip select release
  always_ff @(posedge I_SCK or posedge I_CSN_N) begin
    if (I_CSN_N) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  // output bit, launched on the falling edge
  always_ff @(negedge I_SCK or posedge I_CSN_N) begin
    if (I_CSN_N) begin
      miso_r <= 1'b0;
    end else if (f_r.cnt == `SSCS_DATA_FIRST && f_r.rd) begin
      miso_r <= c_r.rd_data[15];
    end else begin
      miso_r <= f_r.out[15];
    end
  end

  // words and toggles for the core; they must survive chip select
  always_ff @(posedge I_SCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      x_r <= '0;
    end else begin
      x_r <= x_nxt;
    end
  end

  // the sensor only answers on the data line while selected
  assign O_MISO = miso_r;
  assign O_MISO_OE = !I_CSN_N;

  // --------------------------------------------------------------------
  // core side: synchronisers, fetch sequencer, memories
  // --------------------------------------------------------------------

  assign wr_evt = c_r.wr_s2 ^ c_r.wr_seen;
  assign rd_evt = c_r.rd_s2 ^ c_r.rd_seen;
  assign state_chg = (I_SENSOR_STATE != c_r.prev);

  // next state of the core: toggle crossing and read fetch
  always_comb begin
    c_nxt = c_r;
    c_nxt.wr_s1 = x_r.wr_tog;
    c_nxt.wr_s2 = c_r.wr_s1;
    c_nxt.wr_seen = c_r.wr_s2;
    c_nxt.rd_s1 = x_r.rd_tog;
    c_nxt.rd_s2 = c_r.rd_s1;
    c_nxt.rd_seen = c_r.rd_s2;
    c_nxt.prev = I_SENSOR_STATE;
    c_nxt.act_data = active_mem[I_ACT_IDX];
    // a new read request restarts the fetch
    if (rd_evt) begin
      c_nxt.fsm = sscs_pkg::SSCS_FETCH;
      c_nxt.rd_addr = x_r.rd_addr;
      if (I_SENSOR_STATE == sscs_pkg::SSCS_RUNNING) begin
        c_nxt.cnt = 11'(RUN_FETCH_CYC);
      end else begin
        c_nxt.cnt = 11'(CFG_FETCH_CYC);
      end
    end else begin
      case (c_r.fsm)
        sscs_pkg::SSCS_FETCH: begin
          if (c_r.cnt == 11'h000) begin
            c_nxt.rd_data = shadow_mem[idx_of(c_r.rd_addr)];
            c_nxt.fsm = sscs_pkg::SSCS_WAIT;
          end else begin
            c_nxt.cnt = c_r.cnt - 11'h001;
          end
        end
        default: begin
          c_nxt.fsm = sscs_pkg::SSCS_WAIT;
        end
      endcase
    end
  end

  // core state register
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      c_r <= '{fsm: sscs_pkg::SSCS_WAIT, prev: sscs_pkg::SSCS_STANDBY,
               default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  // shadow takes every write in any state; active follows by class
  always_ff @(posedge I_CLK) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!I_RESET_N) begin
        shadow_mem[i] <= `SSCS_DATA_RESET;
        active_mem[i] <= `SSCS_DATA_RESET;
      end else begin
        if (wr_evt && idx_of(x_r.wr_addr) == IDX_W'(i)) begin
          shadow_mem[i] <= x_r.wr_data;
        end
        // frame start in an allowed state, or entering an allowed state
        if ((I_FRAME_START && apply_ok(class_of(i), I_SENSOR_STATE)) ||
            (state_chg && apply_ok(class_of(i), I_SENSOR_STATE))) begin
          active_mem[i] <= shadow_mem[i];
        end
      end
    end
  end

  assign O_ACT_DATA = c_r.act_data;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------

  // the bit count never passes one frame
  chk_frame_count: assert property (
    @(posedge I_SCK) disable iff (I_CSN_N)
    f_r.cnt <= `SSCS_FRAME_BITS)
    else $error("bit count ran past one frame");

  // a read address toggles the request to the core
  chk_read_request: assert property (
    @(posedge I_SCK) disable iff (I_CSN_N || !I_RESET_N)
    (f_r.cnt == `SSCS_ADDR_LAST && !I_MOSI) |=> (x_r.rd_tog != $past(x_r.rd_tog)))
    else $error("read address raised no request");

  // the first data bit carries the msb of the fetched word
  chk_first_bit: assert property (
    @(posedge I_SCK) disable iff (I_CSN_N)
    (f_r.cnt == `SSCS_DATA_FIRST && f_r.rd) |-> (O_MISO == c_r.rd_data[15]))
    else $error("first read bit is not the word msb");

  // a fetch started outside running ends within the config bound
  chk_cfg_fetch: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (rd_evt && I_SENSOR_STATE != sscs_pkg::SSCS_RUNNING) |->
      ##[1:CFG_BOUND] (c_r.fsm == sscs_pkg::SSCS_WAIT))
    else $error("config fetch took too long");

  // cycles spent in the present fetch; the bound is too long for a range
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N || rd_evt || c_r.fsm == sscs_pkg::SSCS_WAIT) begin
      fetch_age_r <= 11'h000;
    end else begin
      fetch_age_r <= fetch_age_r + 11'h001;
    end
  end

  // no fetch, running ones included, outlasts the running bound
  chk_run_fetch: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    fetch_age_r <= 11'(RUN_BOUND))
    else $error("running fetch took too long");

  // a finished fetch returns the shadow word
  chk_read_shadow: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (c_r.fsm == sscs_pkg::SSCS_FETCH && c_r.cnt == 11'h000 && !rd_evt) |=>
      (c_r.rd_data == $past(shadow_mem[idx_of(c_r.rd_addr)])))
    else $error("read did not return the shadow word");

  // a write reaches the shadow memory on the next edge
  chk_write_shadow: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    wr_evt |=> (shadow_mem[idx_of($past(x_r.wr_addr))] == $past(x_r.wr_data)))
    else $error("write missed the shadow memory");

  // an any-state register takes its shadow value at frame start
  chk_frame_apply: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (I_FRAME_START && !CFG_ONLY_MASK[0] && !IDLE_CFG_MASK[0]) |=>
      (active_mem[0] == $past(shadow_mem[0])))
    else $error("frame start did not apply the shadow word");

  // a looked-up configuration-only setting stays put while running
  chk_cfg_hold: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (CFG_ONLY_MASK[I_ACT_IDX] && $stable(I_ACT_IDX) &&
     I_SENSOR_STATE == sscs_pkg::SSCS_RUNNING &&
     c_r.prev == sscs_pkg::SSCS_RUNNING) |=> $stable(c_r.act_data))
    else $error("config-only setting changed while running");

endmodule : sscs_top

`default_nettype wire

// >>> sscs_spi_master.sv
// spi master model: frames to the sensor link, cpol 1 cpha 1
// assumes: the bench calls xfer; sck stands high outside frames
`default_nettype none

module sscs_spi_master (
  output logic o_sck, // serial clock, idles high
  output logic o_csn_n, // chip select, active low
  output logic o_mosi, // serial data to the sensor
  input wire logic i_miso // serial data from the sensor
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle link: clock high, not selected
  initial begin
    // a late first level gives the slave's resets a real edge
    #1;
    o_sck = 1'b1;
    o_csn_n = 1'b1;
    o_mosi = 1'b0;
  end

  // one frame of nbits; sck held high for gap ns after the address
  task automatic xfer(input logic [15:0] adr, input logic [15:0] wd,
    input int gap, input int nbits, output logic [15:0] rd);
    logic [31:0] w;
    w = {adr, wd};
    rd = 16'h0000;
    o_csn_n = 1'b0;
    #7.5;
    for (int i = 0; i < nbits; i++) begin
      o_sck = 1'b0;
      o_mosi = w[31-i];
      #7.5;
      o_sck = 1'b1;
      if (i >= 16) begin
        rd[31-i] = i_miso;
      end
      if (i == 15) begin
        #(gap);
      end else begin
        #7.5;
      end
    end
    o_csn_n = 1'b1;
    o_mosi = ~o_mosi; // released line shows no stale bit
    #15;
  endtask : xfer
endmodule : sscs_spi_master

`default_nettype wire

// >>> sensor_spi_config_slave_tb.sv
// testbench of the sensor spi configuration slave
// assumes: sscs_spi_master drives the link; bench drives core inputs
`default_nettype none

module sensor_spi_config_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CF = 4;
  localparam int RF = 8;
  localparam logic [63:0] CMASK = 64'h2; // index 1 config only
  localparam logic [63:0] IMASK = 64'h4; // index 2 idle or config
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fs = 1'b0;
  logic sck, csn_n, mosi, miso, miso_oe;
  sscs_pkg::sscs_sstate_t st = sscs_pkg::SSCS_CONFIG;
  logic [5:0] idx = 6'h00;
  logic [15:0] act;
  logic [15:0] rd;
  logic [15:0] shad [64];
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;

  sscs_top #(.CFG_FETCH_CYC(CF), .RUN_FETCH_CYC(RF),
    .CFG_ONLY_MASK(CMASK), .IDLE_CFG_MASK(IMASK)) i_dut (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_SCK(sck), .I_CSN_N(csn_n),
    .I_MOSI(mosi), .O_MISO(miso), .O_MISO_OE(miso_oe),
    .I_SENSOR_STATE(st), .I_FRAME_START(fs), .I_ACT_IDX(idx),
    .O_ACT_DATA(act));
  sscs_spi_master i_master (.o_sck(sck), .o_csn_n(csn_n),
    .o_mosi(mosi), .i_miso(miso));

  // core clock, 4 ns
  initial begin
    forever #2 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end

  // --------------------------------------------------------------
  // checks and bus helpers
  // --------------------------------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1

  // frame address: index above the write flag
  function automatic logic [15:0] adr(input logic [5:0] i, input logic w);
    return {9'h000, i, w};
  endfunction : adr

  // fetch allowance in ns for the present state
  function automatic int gap_ns(input sscs_pkg::sscs_sstate_t s);
    return ((s == sscs_pkg::SSCS_RUNNING ? RF : CF) + 10) * 4;
  endfunction : gap_ns

  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    i_master.xfer(adr(i, 1'b1), d, 8, 32, rd);
    shad[i] = d;
    repeat (8) @(posedge clk);
  endtask : wr

  // read with random data bits, which must not write
  task automatic rd_chk(input logic [5:0] i);
    i_master.xfer(adr(i, 1'b0), 16'($urandom), gap_ns(st), 32, rd);
    cmp16(rd, shad[i]);
    repeat (8) @(posedge clk);
  endtask : rd_chk

  task automatic act_chk(input logic [5:0] i, input logic [15:0] e);
    @(posedge clk) idx <= i;
    repeat (2) @(posedge clk);
    #1 cmp16(act, e);
  endtask : act_chk

  task automatic go(input sscs_pkg::sscs_sstate_t s);
    @(posedge clk) st <= s;
    repeat (4) @(posedge clk);
  endtask : go

  task automatic pulse;
    @(posedge clk) fs <= 1'b1;
    @(posedge clk) fs <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic close_out;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic [5:0] k;
    void'($urandom(24));
    for (int i = 0; i < 64; i++) begin
      shad[i] = 16'h0000;
    end
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // reset state of the link and memories
    cmp1(miso_oe, 1'b0);
    act_chk(6'h05, 16'h0000);
    rd_chk(6'h05);
    // random writes in idle, config and running; reads twice
    for (int n = 0; n < 12; n++) begin
      go(sscs_pkg::sscs_sstate_t'(2'(1 + $urandom_range(2))));
      k = 6'(4 + $urandom_range(59));
      d = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h0000 : 16'($urandom);
      wr(k, d);
      rd_chk(k);
      rd_chk(k);
    end
    // shadow held back until the frame start
    go(sscs_pkg::SSCS_RUNNING);
    wr(6'h00, 16'hA5C3);
    act_chk(6'h00, 16'h0000);
    pulse();
    act_chk(6'h00, 16'hA5C3);
    // config-only write while running
    wr(6'h01, 16'h1234);
    rd_chk(6'h01);
    act_chk(6'h01, 16'h0000);
    pulse();
    act_chk(6'h01, 16'h0000);
    go(sscs_pkg::SSCS_CONFIG);
    go(sscs_pkg::SSCS_RUNNING);
    act_chk(6'h01, 16'h1234);
    // config-only write in the configuration state
    go(sscs_pkg::SSCS_CONFIG);
    wr(6'h01, 16'h4321);
    pulse();
    act_chk(6'h01, 16'h4321);
    // idle-or-config register waits for a frame start in idle
    go(sscs_pkg::SSCS_IDLE);
    wr(6'h02, 16'h0F0F);
    act_chk(6'h02, 16'h0000);
    pulse();
    act_chk(6'h02, 16'h0F0F);
    // frame cut one bit short, then a whole frame
    i_master.xfer(adr(6'h03, 1'b1), 16'hFFFF, 8, 31, rd);
    repeat (8) @(posedge clk);
    rd_chk(6'h03);
    wr(6'h04, 16'h5AA5);
    rd_chk(6'h04);
    // any-state register applies on entry to standby; no writes there
    go(sscs_pkg::SSCS_STANDBY);
    act_chk(6'h04, 16'h5AA5);
    close_out();
  end
endmodule : sensor_spi_config_slave_tb

`default_nettype wire
